// File: logic/fch_pkg.sv
// package: feature ids, field layout, status codes and request carriers
//====================================================================
// Operation
// - permissive bit set: background work may overrun non-operational limits
// - permissive bit clear: background work stays within current state limits
// - setting permissive without advertised support fails invalid field
// - get of power state feature returns config word in completion dword
// - progress marker keeps its value across power state changes
// - marker word holds 8-bit load tally in bits 7:0, rest reserved
// - get of progress marker returns its word in completion dword
// - get of host tag feature returns the tag through the data buffer
// - stored host tag decides same-host membership of other controllers
// - config bit 0 picks tag width: 1 is 128-bit, 0 is 64-bit
// - fabric transports use the 128-bit tag form only
// - selecting 128-bit without advertised support fails invalid field
// - width differing from another controller fails inconsistent format
// - on fabric, any set of host tag feature fails sequence error
// - on fabric, get of host tag with 64-bit width fails invalid field
`default_nettype none
package fch_pkg;
	//====================================================================
	// feature ids and fields
	localparam logic [7:0] FID_POWER_PERMIT = 8'h11;
	localparam logic [7:0] FID_BOOT_MARKER  = 8'h80;
	localparam logic [7:0] FID_HOST_TAG     = 8'h81;
	localparam int         PERMIT_BIT       = 0;
	localparam int         WIDE_BIT         = 0;
	localparam int         TALLY_LSB        = 0;
	localparam int         TALLY_W          = 8;
	localparam logic       RST_PERMIT       = 1'b0;
	localparam logic [7:0] RST_TALLY        = 8'h00;
	localparam logic       RST_WIDE         = 1'b0;
	//====================================================================
	// completion status codes
	localparam logic [7:0] ST_SUCCESS       = 8'h00;
	localparam logic [7:0] ST_INVALID_FIELD = 8'h02;
	localparam logic [7:0] ST_SEQ_ERROR     = 8'h0C;
	localparam logic [7:0] ST_TAG_FORMAT    = 8'h22;
	localparam logic [7:0] ST_BAD_FEATURE   = 8'h0D;
	//====================================================================
	// request and answer carriers
	typedef struct packed {
		logic        is_set;
		logic [7:0]  fid;
		logic [31:0] dw11;
	} fch_req_t;
	typedef struct packed {
		logic [7:0]  status;
		logic [31:0] dw0;
		logic        buf_valid;
	} fch_cpl_t;
endpackage
`default_nettype wire

// File: logic/fch_feature_handler.sv
// module: set/get feature interpreter for three configuration features
`timescale 1ns/100ps
`default_nettype none
module fch_feature_handler
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// capabilities and environment, same clock domain
	input  wire logic              cap_permissive,
	input  wire logic              cap_wide_tag,
	input  wire logic              fabric_mode,
	input  wire logic              peer_tag_active,
	input  wire logic              peer_tag_wide,
	input  wire logic [127:0]      peer_tag,
	input  wire logic [127:0]      host_tag_value,
	// command port
	input  wire logic              req_valid,
	input  wire fch_pkg::fch_req_t req,
	output logic                   cpl_valid,
	output fch_pkg::fch_cpl_t      cpl,
	output logic [127:0]           buf_data,
	// effects on the controller
	output logic                   background_power_overrun_enable,
	output logic [7:0]             preboot_load_tally,
	output logic                   wide_host_tag_select,
	output logic                   same_host_peer
);
	//====================================================================
	// request decode
	// set checks run in a fixed order so exactly one status comes back
	function automatic logic [7:0] check_set(input fch_pkg::fch_req_t r, input logic cp,
		input logic cw, input logic fab, input logic pa, input logic pw);
		logic w;
		w = r.dw11[fch_pkg::WIDE_BIT];
		check_set = fch_pkg::ST_SUCCESS;
		case (r.fid)
			fch_pkg::FID_POWER_PERMIT:
				if (r.dw11[fch_pkg::PERMIT_BIT] && !cp)
					check_set = fch_pkg::ST_INVALID_FIELD;
			fch_pkg::FID_BOOT_MARKER:
				check_set = fch_pkg::ST_SUCCESS;
			fch_pkg::FID_HOST_TAG:
				if (fab)
					check_set = fch_pkg::ST_SEQ_ERROR;
				else if (w && !cw)
					check_set = fch_pkg::ST_INVALID_FIELD;
				else if (pa && (pw != w))
					check_set = fch_pkg::ST_TAG_FORMAT;
			default:
				check_set = fch_pkg::ST_BAD_FEATURE;
		endcase
	endfunction

	// get checks; of the three features only a narrow tag read on fabric is refused, unknown ids get bad feature
	function automatic logic [7:0] check_get(input fch_pkg::fch_req_t r, input logic fab);
		check_get = fch_pkg::ST_SUCCESS;
		case (r.fid)
			fch_pkg::FID_POWER_PERMIT:
				check_get = fch_pkg::ST_SUCCESS;
			fch_pkg::FID_BOOT_MARKER:
				check_get = fch_pkg::ST_SUCCESS;
			fch_pkg::FID_HOST_TAG:
				if (fab && !r.dw11[fch_pkg::WIDE_BIT])
					check_get = fch_pkg::ST_INVALID_FIELD;
			default:
				check_get = fch_pkg::ST_BAD_FEATURE;
		endcase
	endfunction

	// request of the given feature, qualified by a strobe
	function automatic logic hits(input logic v, input fch_pkg::fch_req_t r,
		input logic [7:0] f);
		hits = v && (r.fid == f);
	endfunction

	// zero tag means no shared host, so it never matches anyone
	function automatic logic tag_equal(input logic [127:0] mine, input logic [127:0] theirs,
		input logic wide);
		if (wide)
			tag_equal = (mine != 128'h0) && (theirs == mine);
		else
			tag_equal = (mine[63:0] != 64'h0) && (theirs[63:0] == mine[63:0]);
	endfunction

	//====================================================================
	// internal state and answer registers
	// decoded request
	logic [7:0]   set_status;
	logic [7:0]   get_status;
	logic         set_ok;
	logic         get_ok;
	logic         eff_wide;
	// stored features
	logic         permit_reg;
	logic [7:0]   tally_reg;
	logic         wide_reg;
	logic         peer_match_reg;
	// answer registers
	logic         cpl_valid_reg;
	logic [7:0]   status_reg;
	logic [31:0]  dw0_reg;
	logic         buf_valid_reg;
	logic [127:0] buf_data_reg;

	assign set_status = check_set(req, cap_permissive, cap_wide_tag, fabric_mode,
		peer_tag_active, peer_tag_wide);
	assign get_status = check_get(req, fabric_mode);
	assign set_ok     = req_valid && req.is_set && (set_status == fch_pkg::ST_SUCCESS);
	assign get_ok     = req_valid && !req.is_set && (get_status == fch_pkg::ST_SUCCESS);
	// fabric links always run the wide form regardless of stored bit
	assign eff_wide   = fabric_mode | wide_reg;

	//====================================================================
	// feature state; plain registers, untouched by power state changes
	// permission only gates the power manager; the limits themselves live there
	always_ff @(posedge clk)
	begin
		if (reset)
			permit_reg <= fch_pkg::RST_PERMIT;
		else if (hits(set_ok, req, fch_pkg::FID_POWER_PERMIT))
			permit_reg <= req.dw11[fch_pkg::PERMIT_BIT];
	end

	// tally stored as written; saturation is the loader's job
	always_ff @(posedge clk)
	begin
		if (reset)
			tally_reg <= fch_pkg::RST_TALLY;
		else if (hits(set_ok, req, fch_pkg::FID_BOOT_MARKER))
			tally_reg <= req.dw11[fch_pkg::TALLY_LSB +: fch_pkg::TALLY_W];
	end

	// width bit only; the tag payload itself is held outside
	always_ff @(posedge clk)
	begin
		if (reset)
			wide_reg <= fch_pkg::RST_WIDE;
		else if (hits(set_ok, req, fch_pkg::FID_HOST_TAG))
			wide_reg <= req.dw11[fch_pkg::WIDE_BIT];
	end

	// same-host compare follows the width in use right now
	always_ff @(posedge clk)
	begin
		if (reset)
			peer_match_reg <= 1'h0;
		else
			peer_match_reg <= peer_tag_active && tag_equal(host_tag_value, peer_tag, eff_wide);
	end

	//====================================================================
	// completion answers
	// every request is taken; the answer strobe follows one cycle later
	always_ff @(posedge clk)
	begin
		if (reset)
			cpl_valid_reg <= 1'h0;
		else
			cpl_valid_reg <= req_valid;
	end

	// zero status when idle keeps the whole answer word clean
	always_ff @(posedge clk)
	begin
		if (reset)
			status_reg <= fch_pkg::ST_SUCCESS;
		else if (req_valid && req.is_set)
			status_reg <= set_status;
		else if (req_valid)
			status_reg <= get_status;
		else
			status_reg <= fch_pkg::ST_SUCCESS;
	end

	// only the two dword features answer in the completion word
	always_ff @(posedge clk)
	begin
		if (reset)
			dw0_reg <= 32'h0;
		else if (hits(get_ok, req, fch_pkg::FID_POWER_PERMIT))
			dw0_reg <= {31'h0, permit_reg};
		else if (hits(get_ok, req, fch_pkg::FID_BOOT_MARKER))
			dw0_reg <= {24'h0, tally_reg};
		else
			dw0_reg <= 32'h0;
	end

	// tag goes through the data buffer, never the completion word
	always_ff @(posedge clk)
	begin
		if (reset)
			buf_valid_reg <= 1'h0;
		else
			buf_valid_reg <= hits(get_ok, req, fch_pkg::FID_HOST_TAG);
	end

	// narrow form zero-extends so stale upper bits never leak
	always_ff @(posedge clk)
	begin
		if (reset)
			buf_data_reg <= 128'h0;
		else if (!hits(get_ok, req, fch_pkg::FID_HOST_TAG))
			buf_data_reg <= 128'h0;
		else if (eff_wide)
			buf_data_reg <= host_tag_value;
		else
			buf_data_reg <= {64'h0, host_tag_value[63:0]};
	end

	//====================================================================
	// outputs, each taken straight from its register
	assign cpl_valid                       = cpl_valid_reg;
	assign cpl                             = '{status_reg, dw0_reg, buf_valid_reg};
	assign buf_data                        = buf_data_reg;
	assign background_power_overrun_enable = permit_reg;
	assign preboot_load_tally              = tally_reg;
	assign wide_host_tag_select            = wide_reg;
	assign same_host_peer                  = peer_match_reg;
endmodule
`default_nettype wire

// File: verif/fch_assertions.sv
// checker: answer timing and feature rules at the handler ports
`timescale 1ns/100ps
`default_nettype none
module fch_checker
(
	// handler ports
	input wire logic              clk,
	input wire logic              reset,
	input wire logic              cap_permissive,
	input wire logic              fabric_mode,
	input wire logic              req_valid,
	input wire fch_pkg::fch_req_t req,
	input wire logic              cpl_valid,
	input wire fch_pkg::fch_cpl_t cpl,
	input wire logic              background_power_overrun_enable,
	input wire logic [7:0]        preboot_load_tally
);
	//====================================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic s = req_valid && req.is_set;
	wire logic g = req_valid && !req.is_set;
	wire logic p = req.fid == fch_pkg::FID_POWER_PERMIT;
	wire logic m = req.fid == fch_pkg::FID_BOOT_MARKER;
	wire logic h = req.fid == fch_pkg::FID_HOST_TAG;
	sequence s_st(logic [7:0] st); cpl_valid && cpl.status == st; endsequence
	a_answer_next: assert property (req_valid |=> cpl_valid)
		else $error("answer missing");
	a_permit_refused: assert property (s && p && req.dw11[0] && !cap_permissive |=>
		s_st(fch_pkg::ST_INVALID_FIELD) ##0 $stable(background_power_overrun_enable)) else $error("bad refuse");
	a_permit_stored: assert property (s && p && (cap_permissive || !req.dw11[0]) |=>
		background_power_overrun_enable == $past(req.dw11[0])) else $error("permit lost");
	a_permit_read: assert property (g && p |=> cpl.dw0 == {31'h0, background_power_overrun_enable})
		else $error("permit read");
	a_marker_read: assert property (g && m |=> cpl.dw0 == {24'h0, preboot_load_tally})
		else $error("marker read");
	a_marker_kept: assert property (!(s && m) |=> $stable(preboot_load_tally))
		else $error("marker moved");
	a_fabric_locked: assert property (s && h && fabric_mode |=> s_st(fch_pkg::ST_SEQ_ERROR))
		else $error("tag set on fabric");
	a_fabric_narrow: assert property (g && h && fabric_mode && !req.dw11[0] |=> s_st(8'h02))
		else $error("narrow get on fabric");
endmodule
bind fch_feature_handler fch_checker i_fch_checker (.clk, .reset, .cap_permissive, .fabric_mode,
	.req_valid, .req, .cpl_valid, .cpl, .background_power_overrun_enable, .preboot_load_tally);
`default_nettype wire

// File: verif/fch_host_model.sv
// host model: issues one feature request per call
`timescale 1ns/100ps
`default_nettype none
module fch_host_model
(
	// command port
	input  wire logic        clk,
	output logic             req_valid,
	output fch_pkg::fch_req_t req
);
	//====================================================================
	// request driver, idle cycle between requests
	initial req_valid = 1'b0;
	initial req = '0;
	task automatic issue(input logic s, input logic [7:0] f, input logic [31:0] d);
		@(posedge clk);
		#1 req_valid = 1'b1;
		req = '{s, f, d};
		@(posedge clk);
		#1 req_valid = 1'b0;
		req = ~req; // released: driven to the inverse of the last request
	endtask
endmodule
`default_nettype wire

// File: verif/test_feature_config_handler.sv
// bench: random and corner feature requests against the handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module test_feature_config_handler;
	//====================================================================
	// signals and mirror
	logic clk = 1'b0, reset = 1'b1, cap_permissive = 1'b0, cap_wide_tag = 1'b0, fabric_mode = 1'b0;
	logic peer_tag_active = 1'b0, peer_tag_wide = 1'b0, cpl_valid, req_valid, perm = 1'b0, wide = 1'b0;
	logic background_power_overrun_enable, wide_host_tag_select, same_host_peer;
	logic [127:0] peer_tag = '0, host_tag_value = '0, buf_data;
	logic [7:0] preboot_load_tally, tally = 8'h00, st;
	logic [7:0] fid [4] = '{8'h11, 8'h80, 8'h81, 8'h7F};
	int err_count = 0, checked = 0;
	fch_pkg::fch_req_t req;
	fch_pkg::fch_cpl_t cpl;
	always #20 clk = ~clk;
	fch_host_model i_fch_host_model (.clk, .req_valid, .req);
	fch_feature_handler i_fch_feature_handler (.clk, .reset, .cap_permissive, .cap_wide_tag,
		.fabric_mode, .peer_tag_active, .peer_tag_wide, .peer_tag, .host_tag_value, .req_valid,
		.req, .cpl_valid, .cpl, .buf_data, .background_power_overrun_enable, .preboot_load_tally,
		.wide_host_tag_select, .same_host_peer);
	//====================================================================
	// expectations
	function automatic logic [7:0] f_stat(input logic s, input logic [7:0] f, input logic [31:0] d);
		if (f == 8'h11) return (s && d[0] && !cap_permissive) ? 8'h02 : 8'h00;
		if (f == 8'h80) return 8'h00;
		if (f != 8'h81) return fch_pkg::ST_BAD_FEATURE;
		if (fabric_mode) return s ? 8'h0C : (d[0] ? 8'h00 : 8'h02);
		if (!s) return 8'h00;
		if (d[0] && !cap_wide_tag) return 8'h02;
		return (peer_tag_active && peer_tag_wide != d[0]) ? 8'h22 : 8'h00;
	endfunction
	function automatic logic f_peer(input logic w); // zero tag matches nobody
		if (!peer_tag_active) return 1'b0;
		if (fabric_mode || w) return host_tag_value != '0 && peer_tag == host_tag_value;
		return host_tag_value[63:0] != '0 && peer_tag[63:0] == host_tag_value[63:0];
	endfunction
	function automatic logic [127:0] f_buf(input logic ok); // narrow form zero-extends
		if (!ok) return '0;
		return (fabric_mode || wide) ? host_tag_value : {64'h0, host_tag_value[63:0]};
	endfunction
	task automatic go(input logic s, input logic [7:0] f, input logic [31:0] d);
		logic peer_exp;
		peer_exp = f_peer(wide);
		st = f_stat(s, f, d);
		i_fch_host_model.issue(s, f, d);
		`CHK("status", st, cpl.status)
		`CHK("peer", peer_exp, same_host_peer)
		if (st == 8'h00 && s) case (f) 8'h11: perm = d[0]; 8'h80: tally = d[7:0]; 8'h81: wide = d[0]; endcase
		if (!s && f == 8'h11) `CHK("permit", {31'h0, perm}, cpl.dw0)
		if (!s && f == 8'h80) `CHK("marker", {24'h0, tally}, cpl.dw0)
		`CHK("tag_buf", !s && f == 8'h81 && st == 8'h00, cpl.buf_valid)
		`CHK("tag_data", f_buf(!s && f == 8'h81 && st == 8'h00), buf_data)
		`CHK("state", {perm, tally, wide}, {background_power_overrun_enable, preboot_load_tally,
			wide_host_tag_select})
	endtask
	task automatic results;
		if (err_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	//====================================================================
	// sequence: saturating boot count, then random traffic
	initial begin
		void'($urandom(32'h7A60));
		repeat (8) @(posedge clk);
		#1 reset = 1'b0;
		go(1'b1, 8'h80, 32'hFFFF_FFFE);
		repeat (2) go(1'b1, 8'h80, {24'h0, (tally == 8'hFF) ? tally : tally + 8'h01});
		go(1'b0, 8'h80, 32'h0);
		go(1'b1, 8'h80, 32'h0);
		repeat (60) begin
			{cap_permissive, cap_wide_tag, fabric_mode, peer_tag_active, peer_tag_wide} = 5'($urandom);
			host_tag_value = ($urandom % 8 == 0) ? '0 : {$urandom, $urandom, $urandom, $urandom};
			peer_tag = host_tag_value ^ {63'h0, 1'($urandom % 2), 63'h0, 1'($urandom % 3 == 0)};
			go(1'($urandom), fid[$urandom % 4], $urandom);
		end
		results;
	end
	initial begin
		repeat (2000) @(posedge clk);
		err_count++;
		results;
	end
endmodule
`default_nettype wire
